// ---- sync_serial_master_select.sv ----
// Functional notes
// - The master makes the shift clock itself and drives it out on its clock pin.
// - Outgoing data changes on the falling shift clock edge and incoming data is sampled on the rising edge.
// - Bytes are shifted least significant bit first in both directions.
// - There is no clock delay, so bit 0 is on the data pin before the first clock edge.
// - Reception works only with the receive-enable bit set and transmission only with the transmit-enable bit set.
// - Writing the transmit buffer starts a transfer to the selected slave when transmission is enabled.
// - Each received byte raises the receive interrupt and is then readable in the receive buffer; the code raises rxIrq only with RXIRQ_EN_BIT set.
// - The receive buffer word shows overrun at mask 1000h when a byte arrived before the last was read.
// - Each slave has its own active-low select output and only a selected slave takes part.
// - With the select function on, the own select input is monitored during master operation.
// - The bit-rate divider counts the undivided clock and is set for about 1 Mbps.
// - The transmit-complete interrupt is maskable on its own, apart from the receive interrupt.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
module sync_serial_master_select (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             shiftClockPin,
    output logic             serialOutPin,
    input  wire logic        serialInPin,
    input  wire logic        ownSelectInputN,
    output logic             slaveOneSelectN,
    output logic             slaveTwoSelectN,
    output logic      [7:0]  receivedBytePort,
    output logic             rxIrq,
    output logic             txIrq
);
    import sync_serial_pkg::*;

    typedef struct packed {
        logic              ack;
        logic [31:0]       rdat;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0]        div;
        logic [1:0]        sel;
        shift_state_t      ph;
        logic [2:0]        bitIdx;
        logic [7:0]        txSh;
        logic [7:0]        rxSh;
        logic              sclk;
        logic              sdo;
        logic [7:0]        rxData;
        logic              rxFull;
        logic              ovr;
        logic              fault;
        logic              rxIrq;
        logic              txIrq;
        logic [1:0]        sync1;
        logic [1:0]        sync2;
    } core_t;

    core_t cur;
    core_t next_cur;

    logic       access;
    logic       start;
    logic       done;
    logic       abort;
    logic [7:0] inByte;

    rate_if rate ();

    rate_tick_gen u_rate (
        .mclk   (mclk),
        .resetn (resetn),
        .rate   (rate)
    );

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return {adr[7:2], 2'b00} == ofs;
    endfunction

    assign rate.run     = cur.ph != SH_IDLE;
    assign rate.divisor = cur.div;

    always_comb begin
        next_cur       = cur;
        next_cur.rxIrq = 1'b0;
        next_cur.txIrq = 1'b0;
        // sync1 feeds sync2 only; bit 0 data in, bit 1 own select
        next_cur.sync1 = {ownSelectInputN, serialInPin};
        next_cur.sync2 = cur.sync1;
        access         = wb_cyc_i && wb_stb_i && !cur.ack;
        next_cur.ack   = access;
        start          = 1'b0;
        done           = 1'b0;
        abort          = cur.ctrl[SEL_FN_BIT] && cur.ph != SH_IDLE && !cur.sync2[1];
        inByte         = {cur.sync2[0], cur.rxSh[7:1]};

        if (access && wb_we_i && wb_sel_i[0]) begin
            if (hit(wb_adr_i, CTRL_OFS)) begin
                next_cur.ctrl = wb_dat_i[CTRL_W-1:0];
            end
            if (hit(wb_adr_i, DIV_OFS)) begin
                next_cur.div = wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, SEL_OFS)) begin
                next_cur.sel = wb_dat_i[1:0];
            end
            // a write while off or busy is dropped
            if (hit(wb_adr_i, TXBUF_OFS) && cur.ctrl[TX_ON_BIT] && cur.ph == SH_IDLE) begin
                start = 1'b1;
            end
        end

        if (access && !wb_we_i) begin
            case ({wb_adr_i[7:2], 2'b00})
                CTRL_OFS:  next_cur.rdat = 32'(cur.ctrl);
                DIV_OFS:   next_cur.rdat = 32'(cur.div);
                SEL_OFS:   next_cur.rdat = 32'(cur.sel);
                RXBUF_OFS: begin
                    next_cur.rdat = 32'(cur.rxData) | (cur.ovr ? OVERRUN_FLAG_MASK : 32'h0000_0000);
                    next_cur.rxFull = 1'b0;
                    next_cur.ovr    = 1'b0;
                end
                STAT_OFS: begin
                    next_cur.rdat = '0;
                    next_cur.rdat[ST_BUSY]   = cur.ph != SH_IDLE;
                    next_cur.rdat[ST_FULL]   = cur.rxFull;
                    next_cur.rdat[ST_OVR]    = cur.ovr;
                    next_cur.rdat[ST_FAULT]  = cur.fault;
                    next_cur.rdat[ST_OWNSEL] = cur.sync2[1];
                    next_cur.fault           = 1'b0;
                end
                default:   next_cur.rdat = 32'h0000_0000;
            endcase
        end

        case (cur.ph)
            SH_IDLE: begin
                next_cur.sclk = 1'b1;
                if (start) begin
                    // bit 0 goes out at once, no half-cycle lead
                    next_cur.sdo    = wb_dat_i[0];
                    next_cur.txSh   = {1'b0, wb_dat_i[7:1]};
                    next_cur.bitIdx = 3'h0;
                    next_cur.ph     = SH_FALL;
                end
            end
            SH_FALL: begin
                if (rate.tick) begin
                    next_cur.sclk = 1'b0;
                    if (cur.bitIdx != 3'h0) begin
                        next_cur.sdo  = cur.txSh[0];
                        next_cur.txSh = {1'b0, cur.txSh[7:1]};
                    end
                    next_cur.ph = SH_RISE;
                end
            end
            SH_RISE: begin
                if (rate.tick) begin
                    next_cur.sclk = 1'b1;
                    next_cur.rxSh = inByte;
                    if (cur.bitIdx == 3'(BYTE_BITS - 1)) begin
                        done        = 1'b1;
                        next_cur.ph = SH_IDLE;
                    end else begin
                        next_cur.bitIdx = cur.bitIdx + 3'h1;
                        next_cur.ph     = SH_FALL;
                    end
                end
            end
            default: next_cur.ph = SH_IDLE;
        endcase

        // a cut transfer leaves no byte and no interrupt
        if (done && !abort) begin
            next_cur.txIrq = cur.ctrl[TXIRQ_EN_BIT];
            if (cur.ctrl[RX_ON_BIT]) begin
                // a new byte wins over a read in the same cycle
                next_cur.rxData = inByte;
                next_cur.rxFull = 1'b1;
                next_cur.rxIrq  = cur.ctrl[RXIRQ_EN_BIT];
                if (cur.rxFull) begin
                    next_cur.ovr = 1'b1;
                end
            end
        end

        // another master pulled our select low: abort
        if (abort) begin
            next_cur.ph    = SH_IDLE;
            next_cur.sclk  = 1'b1;
            next_cur.fault = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur       <= '0;
            cur.ctrl  <= CTRL_RESET;
            cur.div   <= DIV_RESET;
            cur.sel   <= SEL_RESET;
            cur.ph    <= SH_IDLE;
            cur.sclk  <= 1'b1;
            cur.sdo   <= 1'b1;
            cur.sync1 <= 2'h3;
            cur.sync2 <= 2'h3;
        end else begin
            cur <= next_cur;
        end
    end

    assign wb_ack_o         = cur.ack;
    assign wb_dat_o         = cur.rdat;
    assign shiftClockPin    = cur.sclk;
    assign serialOutPin     = cur.sdo;
    assign slaveOneSelectN  = cur.sel[0];
    assign slaveTwoSelectN  = cur.sel[1];
    assign receivedBytePort = cur.rxData;
    assign rxIrq            = cur.rxIrq;
    assign txIrq            = cur.txIrq;

    // rising shift clock edges since the transfer began
    logic [3:0] riseCnt;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            riseCnt <= 4'h0;
        end else if (start) begin
            riseCnt <= 4'h0;
        end else if (cur.sclk == 1'b0 && next_cur.sclk == 1'b1) begin
            riseCnt <= riseCnt + 4'h1;
        end
    end

    idle_clock_a: assert property (@(posedge mclk) disable iff (!resetn)
        cur.ph == SH_IDLE |-> shiftClockPin)
        else $error("shift clock low while idle");
    data_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(serialOutPin) && $past(cur.ph) != SH_IDLE |-> $fell(shiftClockPin))
        else $error("data changed away from a falling edge");
    first_bit_a: assert property (@(posedge mclk) disable iff (!resetn)
        start |=> serialOutPin == $past(wb_dat_i[0]) && shiftClockPin && cur.ph == SH_FALL)
        else $error("bit 0 not presented at start");
    tx_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
        access && wb_we_i && hit(wb_adr_i, TXBUF_OFS) && !cur.ctrl[TX_ON_BIT] && cur.ph == SH_IDLE
        |=> cur.ph == SH_IDLE)
        else $error("transfer began with transmission off");
    tx_start_a: assert property (@(posedge mclk) disable iff (!resetn)
        access && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, TXBUF_OFS) && cur.ctrl[TX_ON_BIT]
        && cur.ph == SH_IDLE |=> cur.ph == SH_FALL)
        else $error("transmit buffer write did not start");
    rx_irq_a: assert property (@(posedge mclk) disable iff (!resetn)
        rxIrq |-> cur.rxFull && receivedBytePort == cur.rxSh)
        else $error("receive interrupt without the byte");
    overrun_set_a: assert property (@(posedge mclk) disable iff (!resetn)
        done && cur.ctrl[RX_ON_BIT] && cur.rxFull |=> cur.ovr)
        else $error("overrun not flagged");
    own_select_a: assert property (@(posedge mclk) disable iff (!resetn)
        cur.ctrl[SEL_FN_BIT] && cur.ph != SH_IDLE && !cur.sync2[1] |=> cur.ph == SH_IDLE && cur.fault)
        else $error("own select low did not stop the transfer");
    tx_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(cur.ph == SH_IDLE) && !$past(cur.ctrl[TXIRQ_EN_BIT]) |-> !txIrq)
        else $error("masked transmit interrupt fired");
    eight_bits_a: assert property (@(posedge mclk) disable iff (!resetn)
        done |-> riseCnt == 4'h7 && cur.bitIdx == 3'h7)
        else $error("transfer did not take eight clocks");

    first_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        cur.ph == SH_FALL && cur.bitIdx == 3'h0 |=> $stable(serialOutPin))
        else $error("bit 0 moved before the first falling edge");
    rise_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(shiftClockPin) |-> $stable(serialOutPin))
        else $error("data changed on a rising edge");
    sample_edge_a: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(cur.rxSh) |-> $rose(shiftClockPin))
        else $error("input bit taken away from a rising edge");
    clock_tick_a: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(shiftClockPin) |-> $past(rate.tick) || $past(abort))
        else $error("shift clock moved without a divider tick");
    rx_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
        done && !cur.ctrl[RX_ON_BIT] |=> !rxIrq && $stable(receivedBytePort))
        else $error("byte stored with reception off");
    rx_store_a: assert property (@(posedge mclk) disable iff (!resetn)
        done && !abort && cur.ctrl[RX_ON_BIT]
        |=> receivedBytePort == $past(inByte) && rxIrq == $past(cur.ctrl[RXIRQ_EN_BIT]))
        else $error("received byte or interrupt missing");
    tx_irq_a: assert property (@(posedge mclk) disable iff (!resetn)
        done && !abort |=> txIrq == $past(cur.ctrl[TXIRQ_EN_BIT]))
        else $error("transmit interrupt does not follow its enable");
    abort_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
        abort |=> !rxIrq && !txIrq)
        else $error("interrupt after a cut transfer");
    ovr_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
        access && !wb_we_i && hit(wb_adr_i, RXBUF_OFS) && !done |=> !cur.ovr && !cur.rxFull)
        else $error("receive buffer read did not clear the flags");
    select_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        !(access && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, SEL_OFS))
        |=> $stable({slaveTwoSelectN, slaveOneSelectN}))
        else $error("select output moved without a select write");

    // the bus answers every new request after one cycle
    ack_latency_a: assert property (@(posedge mclk) disable iff (!resetn)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_once_a: assert property (@(posedge mclk) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
endmodule // sync_serial_master_select

// ---- sync_serial_pkg.sv ----
package sync_serial_pkg;
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          BIT_RATE_HZ   = 1_000_000;
    // half a bit period in mclk cycles, minus one
    localparam logic [7:0]  DIV_RESET     = 8'(CLK_HZ / (2 * BIT_RATE_HZ) - 1);
    localparam int          BYTE_BITS     = 8;

    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  TXBUF_OFS     = 8'h04;
    localparam logic [7:0]  RXBUF_OFS     = 8'h08;
    localparam logic [7:0]  DIV_OFS       = 8'h0C;
    localparam logic [7:0]  SEL_OFS       = 8'h10;
    localparam logic [7:0]  STAT_OFS      = 8'h14;

    localparam int          TX_ON_BIT     = 0;
    localparam int          RX_ON_BIT     = 1;
    localparam int          SEL_FN_BIT    = 2;
    localparam int          TXIRQ_EN_BIT  = 3;
    localparam int          RXIRQ_EN_BIT  = 4;
    localparam int          CTRL_W        = 5;
    localparam logic [4:0]  CTRL_RESET    = 5'h00;
    localparam logic [1:0]  SEL_RESET     = 2'h3;
    localparam logic [31:0] OVERRUN_FLAG_MASK = 32'h0000_1000;

    localparam int          ST_BUSY       = 0;
    localparam int          ST_FULL       = 1;
    localparam int          ST_OVR        = 2;
    localparam int          ST_FAULT      = 3;
    localparam int          ST_OWNSEL     = 4;

    typedef enum logic [1:0] {
        SH_IDLE,
        SH_FALL,
        SH_RISE
    } shift_state_t;
endpackage

// ---- rate_if.sv ----
interface rate_if;
    logic       run;
    logic [7:0] divisor;
    logic       tick;
    modport ctrl (output run, output divisor, input tick);
    modport gen  (input run, input divisor, output tick);
endinterface

// ---- rate_tick_gen.sv ----
module rate_tick_gen (
    input wire logic mclk,
    input wire logic resetn,
    rate_if.gen      rate
);
    import sync_serial_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } div_state_t;

    div_state_t cur;
    div_state_t next_cur;

    // counts undivided mclk, one tick per half bit period
    always_comb begin
        next_cur      = cur;
        next_cur.tick = 1'b0;
        if (!rate.run) begin
            next_cur.count = 8'h00;
        end else if (cur.count >= rate.divisor) begin
            next_cur.count = 8'h00;
            next_cur.tick  = 1'b1;
        end else begin
            next_cur.count = cur.count + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rate.tick = cur.tick;

    tick_spacing_a: assert property (@(posedge mclk) disable iff (!resetn)
        rate.tick && rate.run && rate.divisor != 8'h00 |=> !rate.tick)
        else $error("tick came on two adjacent cycles");
    tick_stopped_a: assert property (@(posedge mclk) disable iff (!resetn)
        !rate.run ##1 !rate.run |-> !rate.tick)
        else $error("tick while divider stopped");
endmodule // rate_tick_gen

// ---- slave_model.sv ----
module slave_model (
    input  wire logic       sclk,
    input  wire logic       selN,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic      [7:0] got,
    output int              bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    initial begin
        miso = 1'b1;
        got  = 8'h00;
        bits = 0;
    end
    // bit 0 stands on the line before the first clock edge
    always @(negedge selN) begin
        sh   = reply;
        miso = reply[0];
        bits = 0;
    end
    // a released line must not keep showing the last bit
    always @(posedge selN) miso = ~miso;
    always @(negedge sclk) if (!selN && bits > 0) begin
        sh   = sh >> 1;
        miso = sh[0];
    end
    always @(posedge sclk) if (!selN) begin
        got  = {mosi, got[7:1]};
        bits = bits + 1;
    end
endmodule // slave_model

// ---- tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sync_serial_pkg::*;
    logic        mclk, resetn, wbCyc, wbStb, wbWe, wbAck, ownSelN;
    logic        sclk, sdo, sdi, s1n, s2n, rxIrq, txIrq, m1, m2, lastClk;
    logic [7:0]  wbAdr, r1, r2, port, got1, got2;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI, wbDatO;
    int          bits1, bits2, errorCnt = 0, comparisons = 0;
    int          cnt = 0, per = 0, falls = 0, rxCnt = 0, txCnt = 0;

    sync_serial_master_select u_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .shiftClockPin(sclk), .serialOutPin(sdo), .serialInPin(sdi),
        .ownSelectInputN(ownSelN), .slaveOneSelectN(s1n), .slaveTwoSelectN(s2n),
        .receivedBytePort(port), .rxIrq(rxIrq), .txIrq(txIrq));
    slave_model u_one (.sclk(sclk), .selN(s1n), .mosi(sdo), .reply(r1), .miso(m1), .got(got1), .bits(bits1));
    slave_model u_two (.sclk(sclk), .selN(s2n), .mosi(sdo), .reply(r2), .miso(m2), .got(got2), .bits(bits2));
    assign sdi = !s1n ? m1 : m2;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // counts shift clock falls, their spacing and the interrupt pulses
    always @(posedge mclk) begin
        cnt = cnt + 1;
        if (txIrq === 1'b1) txCnt = txCnt + 1;
        if (rxIrq === 1'b1) rxCnt = rxCnt + 1;
        if (lastClk === 1'b1 && sclk === 1'b0) begin
            per   = cnt;
            cnt   = 0;
            falls = falls + 1;
        end
        lastClk = sclk;
    end

    task automatic completeRun;
        if (errorCnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbDatI <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        q = wbDatO;
        chk({31'h0, wbAck}, 32'h1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic send(input logic [1:0] sel, input logic [7:0] d);
        wr(SEL_OFS, 32'h3);
        wr(SEL_OFS, {30'h0, sel});
        wr(TXBUF_OFS, {24'h0, d});
    endtask
    task automatic waitIdle;
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            wb(1'b0, STAT_OFS, 32'h0, q);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 1000);
        chk({31'h0, q[ST_BUSY]}, 32'h0);
    endtask

    task automatic sReset;
        chk({sclk, sdo, s1n, s2n, rxIrq, txIrq, port}, 32'h3C00);
        rd(CTRL_OFS, 32'h0);
        rd(DIV_OFS, 32'h31);
        rd(SEL_OFS, 32'h3);
        rd(8'h1C, 32'h0);
        rd(TXBUF_OFS, 32'h0);
    endtask
    task automatic sDuplex;
        r1 = 8'hA3;
        wr(CTRL_OFS, 32'h13);
        send(2'b10, 8'h55);
        waitIdle;
        chk(got1, 8'h55);
        chk(bits2, 0);
        chk(falls, 8);
        chk(per, 100);
        chk(port, 8'hA3);
        chk(rxCnt, 1);
        chk(txCnt, 0);
        rd(RXBUF_OFS, 32'hA3);
    endtask
    task automatic sOverrun;
        wr(CTRL_OFS, 32'h1B);
        r2 = 8'h3C;
        send(2'b01, 8'hAA);
        waitIdle;
        chk(got2, 8'hAA);
        r2 = 8'hC5;
        send(2'b01, 8'h81);
        waitIdle;
        chk(got2, 8'h81);
        chk(txCnt, 2);
        chk(rxCnt, 3);
        rd(RXBUF_OFS, 32'h10C5);
        rd(RXBUF_OFS, 32'hC5);
    endtask
    task automatic sEnables;
        wr(CTRL_OFS, 32'h12);
        wr(TXBUF_OFS, 32'h0F);
        repeat (300) @(posedge mclk);
        chk(falls, 24);
        wr(CTRL_OFS, 32'h19);
        r1 = 8'h5A;
        send(2'b10, 8'h0F);
        waitIdle;
        chk(got1, 8'h0F);
        chk(rxCnt, 3);
        chk(port, 8'hC5);
        chk(txCnt, 3);
        rd(STAT_OFS, 32'h10);
    endtask
    task automatic sAbort;
        wr(CTRL_OFS, 32'h17);
        send(2'b10, 8'h66);
        repeat (200) @(posedge mclk);
        ownSelN <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(sclk, 1);
        rd(STAT_OFS, 32'h08);
        chk(rxCnt, 3);
        ownSelN <= 1'b1;
    endtask

    initial begin
        resetn  = 1'b0;
        wbCyc   = 1'b0;
        wbStb   = 1'b0;
        wbWe    = 1'b0;
        wbAdr   = 8'h00;
        wbSel   = 4'hF;
        wbDatI  = 32'h0;
        ownSelN = 1'b1;
        r1      = 8'h00;
        r2      = 8'h00;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        sReset;
        sDuplex;
        sOverrun;
        sEnables;
        sAbort;
        completeRun;
    end
    // five transfers of about 800 cycles, the last cut short, plus polling stay well inside this span
    initial begin
        repeat (30000) @(posedge mclk);
        errorCnt++;
        completeRun;
    end
endmodule // tb_top
